//--- design/amrg_regs.sv
`timescale 1ns/10ps
`include "amrg_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Bit15 enables mixer; bit12 routes right DAC.
// - Bit11 routes left DAC into mixer.
// - Bit10 attenuates second aux output 6dB.
// - Bit9 routes right record mixer in.
// - Bit1 routes right playback mixer in.
// - Bit0 routes left playback mixer in.
// - Gain code 000 off, 001 -12dB, 3dB steps.
// - Left play bits 11:9 third left gain.
// - Left play bits 7:5 right amplifier gain.
// - Left play bits 3:1 left amplifier gain.
// - Right play bits 15:13 third right gain.
// - Right play bits 7:5 right amplifier gain.
// - Right play bits 3:1 left amplifier gain.
// - Left record bits 11:9 third left gain.
// - Left record bits 3:1 second left gain.
// - Left record bit0 gives 20dB boost.
//////////////////////////////////////////////////////////////////////////////
module amrg_regs #(
    parameter int ADDR_W = 12 // APB address width.
) (
    input wire logic clk_i, // 250 MHz clock.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic psel_i, // APB select.
    input wire logic penable_i, // APB enable.
    input wire logic pwrite_i, // APB direction, high for write.
    input wire logic [ADDR_W-1:0] paddr_i, // APB byte address.
    input wire logic [31:0] pwdata_i, // APB write data.
    input wire logic [3:0] pstrb_i, // APB byte strobes.
    output logic [31:0] prdata_o, // APB read data.
    output logic pready_o, // APB ready.
    output logic pslverr_o, // APB error on unmapped address.
    output logic aux_out_b_mixer_enable_o, // Second aux mixer on.
    output logic right_dac_to_aux_b_o, // Right DAC into mixer.
    output logic left_dac_to_aux_b_o, // Left DAC into mixer.
    output logic aux_b_minus_6db_o, // 6dB attenuation on.
    output logic right_rec_mix_to_aux_b_o, // Right record mix into mixer.
    output logic right_play_mix_to_aux_b_o, // Right play mix into mixer.
    output logic left_play_mix_to_aux_b_o, // Left play mix into mixer.
    output logic [11:0] path_connected_o, // Per-path connected flags.
    output logic [71:0] path_gain_db_o, // Per-path gain, signed half-dB, 6 bits each.
    output logic left_pga_rec_boost_o // Left amplifier record boost on.
);
    // Refuse address widths that cannot reach the highest register index.
    if (ADDR_W < 10)
    begin : g_addr_w_chk
        $error("ADDR_W too small for register map.");
    end

    //////////////////////////////////////////////////////////////////////////
    // Storage.
    // Each register keeps only its writable bits; everything else is held at zero,
    // so a read returns zero for reserved bits without any extra masking.
    // The unsupported routing bit of the control register is never stored at all,
    // which keeps a careless driver from enabling a path the mixer cannot serve.
    logic [15:0] auxb_r; // Second aux mixer control.
    logic [15:0] lplay_r; // Left playback mixer gains.
    logic [15:0] rplay_r; // Right playback mixer gains.
    logic [15:0] lrec_r; // Left record mixer gains.
    logic [15:0] rdata_nxt; // Read mux value.
    logic hit_nxt; // Address is mapped.
    logic [15:0] wmask_nxt; // Byte-strobe mask.
    logic [15:0] wv_nxt; // Write data low half.
    logic [35:0] codes_nxt; // Twelve gain fields, gathered.
    logic [11:0] conn_nxt; // Connected flags.
    logic [71:0] db_nxt; // Decoded gains.

    // Gain decode: 000 disconnected, 001 is -12dB, 3dB per code step.
    // The product overflows six bits for high codes, but the result is taken
    // modulo 64, so the final difference lands on the right signed value.
    // Code 000 is filtered by the caller; its raw value here has no meaning.
    function automatic amrg_pkg::amrg_gain_db_t gain_db(input amrg_pkg::amrg_gain_code_t c);
        gain_db = 6'(6'sd6 * $signed({3'b000, c}) - 6'sd30);
    endfunction : gain_db

    // Index match on word address.
    function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [7:0] i);
        idx_is = (a[ADDR_W-1:2] == (ADDR_W-2)'(i)) && (a[1:0] == 2'b00);
    endfunction : idx_is

    //////////////////////////////////////////////////////////////////////////
    // Address decode and read mux; unlisted bits read zero.
    // Only aligned word addresses hit; byte offsets inside a word are refused,
    // because a partial address would make the strobe mapping ambiguous.
    // The decode is purely combinational and is registered by the bus process.
    always_comb
    begin
        hit_nxt = 1'b1;
        if (idx_is(paddr_i, `AMRG_IDX_AUXB_CTRL))
        begin
            rdata_nxt = auxb_r;
        end
        else if (idx_is(paddr_i, `AMRG_IDX_LPLAY_GAIN))
        begin
            rdata_nxt = lplay_r;
        end
        else if (idx_is(paddr_i, `AMRG_IDX_RPLAY_GAIN))
        begin
            rdata_nxt = rplay_r;
        end
        else if (idx_is(paddr_i, `AMRG_IDX_LREC_GAIN))
        begin
            rdata_nxt = lrec_r;
        end
        else
        begin
            rdata_nxt = 16'h0000;
            hit_nxt = 1'b0;
        end
        wmask_nxt = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
        wv_nxt = pwdata_i[15:0];
    end

    // APB answers in the access cycle; zero wait states.
    // Ready is a registered copy of the setup phase, so it rises exactly in the
    // first access cycle and falls again at the next edge.
    // Read data is driven only together with ready and is zero otherwise.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit_nxt;
            prdata_o <= (psel_i && !penable_i && !pwrite_i) ? {16'h0000, rdata_nxt}
                                                              : 32'h0000_0000;
        end
    end

    // Writes land at the edge that completes the access phase.
    // Byte strobes select which half of the 16-bit word is updated; the upper
    // strobes have no storage behind them and are ignored.
    // Unmapped or misaligned writes fall through and change nothing.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            auxb_r <= `AMRG_RST;
            lplay_r <= `AMRG_RST;
            rplay_r <= `AMRG_RST;
            lrec_r <= `AMRG_RST;
        end
        else if (psel_i && penable_i && pready_o && pwrite_i)
        begin
            if (idx_is(paddr_i, `AMRG_IDX_AUXB_CTRL))
            begin
                // Bit 2 is not writable, so unsupported routing can never be enabled.
                auxb_r <= (auxb_r & ~(wmask_nxt & `AMRG_M_AUXB))
                        | (wv_nxt & wmask_nxt & `AMRG_M_AUXB);
            end
            else if (idx_is(paddr_i, `AMRG_IDX_LPLAY_GAIN))
            begin
                lplay_r <= (lplay_r & ~(wmask_nxt & `AMRG_M_LPLAY))
                         | (wv_nxt & wmask_nxt & `AMRG_M_LPLAY);
            end
            else if (idx_is(paddr_i, `AMRG_IDX_RPLAY_GAIN))
            begin
                rplay_r <= (rplay_r & ~(wmask_nxt & `AMRG_M_RPLAY))
                         | (wv_nxt & wmask_nxt & `AMRG_M_RPLAY);
            end
            else if (idx_is(paddr_i, `AMRG_IDX_LREC_GAIN))
            begin
                lrec_r <= (lrec_r & ~(wmask_nxt & `AMRG_M_LREC))
                        | (wv_nxt & wmask_nxt & `AMRG_M_LREC);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Gather gain fields: index 0..2 left play, 3..5 right play, 6..7 left rec.
    // Slots 8 to 11 are spare so the output bus keeps room for later paths.
    always_comb
    begin
        codes_nxt = 36'h0_0000_0000;
        codes_nxt[2:0] = lplay_r[`AMRG_F_MID3 -: 3];
        codes_nxt[5:3] = lplay_r[`AMRG_F_PGA_R -: 3];
        codes_nxt[8:6] = lplay_r[`AMRG_F_PGA_L -: 3];
        codes_nxt[11:9] = rplay_r[`AMRG_F_HI3 -: 3];
        codes_nxt[14:12] = rplay_r[`AMRG_F_PGA_R -: 3];
        codes_nxt[17:15] = rplay_r[`AMRG_F_PGA_L -: 3];
        codes_nxt[20:18] = lrec_r[`AMRG_F_MID3 -: 3];
        codes_nxt[23:21] = lrec_r[`AMRG_F_PGA_L -: 3];
    end

    // Decode each path; spare slots stay disconnected.
    // A disconnected path reports zero gain so that downstream logic never
    // mistakes a stale code for a live level.
    for (genvar g = 0; g < 12; g++)
    begin : g_dec
        assign conn_nxt[g] = codes_nxt[3*g +: 3] != 3'b000;
        assign db_nxt[6*g +: 6] = conn_nxt[g] ? gain_db(codes_nxt[3*g +: 3]) : 6'h00;
    end

    // Control outputs registered from storage.
    // Every output comes from a flip-flop, one cycle after the register bit,
    // so the analogue controls never see the glitches of the decode logic.
    // The cost is one cycle of latency after each write, which is harmless here.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            aux_out_b_mixer_enable_o <= 1'b0;
            right_dac_to_aux_b_o <= 1'b0;
            left_dac_to_aux_b_o <= 1'b0;
            aux_b_minus_6db_o <= 1'b0;
            right_rec_mix_to_aux_b_o <= 1'b0;
            right_play_mix_to_aux_b_o <= 1'b0;
            left_play_mix_to_aux_b_o <= 1'b0;
            path_connected_o <= 12'h000;
            path_gain_db_o <= 72'h00_0000_0000_0000_0000;
            left_pga_rec_boost_o <= 1'b0;
        end
        else
        begin
            aux_out_b_mixer_enable_o <= auxb_r[`AMRG_B_AUXB_ENA];
            right_dac_to_aux_b_o <= auxb_r[`AMRG_B_RDAC];
            left_dac_to_aux_b_o <= auxb_r[`AMRG_B_LDAC];
            aux_b_minus_6db_o <= auxb_r[`AMRG_B_ATTN];
            right_rec_mix_to_aux_b_o <= auxb_r[`AMRG_B_RREC];
            right_play_mix_to_aux_b_o <= auxb_r[`AMRG_B_RPLAY];
            left_play_mix_to_aux_b_o <= auxb_r[`AMRG_B_LPLAY];
            path_connected_o <= conn_nxt;
            path_gain_db_o <= db_nxt;
            left_pga_rec_boost_o <= lrec_r[`AMRG_B_BOOST];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks.
    // The properties below compare each registered output with the storage bit
    // or field that feeds it, one cycle earlier.
    // Gain values are in signed half-dB units: -12dB is -24, which is 6'h28,
    // -9dB is -18, which is 6'h2e, and +6dB is +12, which is 6'h0c.
    // Slot n of the gain bus occupies bits 6n+5 down to 6n.
    // All checks are disabled during reset, where every output is forced low.
    // The bus checks watch only what the block drives: ready, error and data.
    // Reserved bits of the control and left playback registers are checked directly
    // in storage, since they never reach an output and would otherwise escape notice.
    property p_enable;
        @(posedge clk_i) disable iff (srst_i)
        1'b1 |=> aux_out_b_mixer_enable_o == $past(auxb_r[15]);
    endproperty
    a_enable: assert property (p_enable) else $error("Mixer enable mismatch.");
    property p_ldac;
        @(posedge clk_i) disable iff (srst_i)
        $rose(auxb_r[11]) |=> left_dac_to_aux_b_o;
    endproperty
    a_ldac: assert property (p_ldac) else $error("Left DAC route late.");
    property p_attn;
        @(posedge clk_i) disable iff (srst_i) $fell(auxb_r[10]) |=> !aux_b_minus_6db_o;
    endproperty
    a_attn: assert property (p_attn) else $error("Attenuation stuck.");
    property p_rrec;
        @(posedge clk_i) disable iff (srst_i)
        $changed(auxb_r[9]) |=> $changed(right_rec_mix_to_aux_b_o);
    endproperty
    a_rrec: assert property (p_rrec) else $error("Record route lag.");
    property p_bit2;
        @(posedge clk_i) disable iff (srst_i) auxb_r[2] == 1'b0;
    endproperty
    a_bit2: assert property (p_bit2) else $error("Unsupported bit set.");
    property p_play;
        @(posedge clk_i) disable iff (srst_i)
        ##1 {right_play_mix_to_aux_b_o, left_play_mix_to_aux_b_o} == $past(auxb_r[1:0]);
    endproperty
    a_play: assert property (p_play) else $error("Play routes mismatch.");
    property p_gain;
        @(posedge clk_i) disable iff (srst_i)
        (lplay_r[11:9] == 3'b001) |=> path_connected_o[0] && path_gain_db_o[5:0] == 6'h28;
    endproperty
    a_gain: assert property (p_gain) else $error("Gain -12dB decode wrong.");
    property p_top;
        @(posedge clk_i) disable iff (srst_i)
        (rplay_r[15:13] == 3'b111) |=> path_gain_db_o[23:18] == 6'h0c;
    endproperty
    a_top: assert property (p_top) else $error("Gain +6dB decode wrong.");
    property p_off;
        @(posedge clk_i) disable iff (srst_i)
        (lrec_r[3:1] == 3'b000) |=> !path_connected_o[7];
    endproperty
    a_off: assert property (p_off) else $error("Path not disconnected.");
    property p_boost;
        @(posedge clk_i) disable iff (srst_i) ##1 left_pga_rec_boost_o == $past(lrec_r[0]);
    endproperty
    a_boost: assert property (p_boost) else $error("Boost mismatch.");
    property p_ready;
        @(posedge clk_i) disable iff (srst_i) (psel_i && !penable_i) |=> pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("Ready missing.");
    c_wr: cover property (@(posedge clk_i) psel_i && penable_i && pready_o && pwrite_i);
    c_err: cover property (@(posedge clk_i) pslverr_o && pready_o);
    c_en: cover property (@(posedge clk_i) aux_out_b_mixer_enable_o);
    // Further checks on routing, decode, spare slots and bus answers.
    // Each gain value check names a fixed code so that a broken decode cannot pass by
    // agreeing with itself.
    // Right DAC route follows its bit one cycle later.
    property p_rdac;
        @(posedge clk_i) disable iff (srst_i)
        $rose(auxb_r[12]) |=> right_dac_to_aux_b_o;
    endproperty
    a_rdac: assert property (p_rdac) else $error("Right DAC route late.");
    // A non-zero code connects the right amplifier path into left playback.
    property p_lplay_mid;
        @(posedge clk_i) disable iff (srst_i)
        (lplay_r[7:5] != 3'b000) |=> path_connected_o[1];
    endproperty
    a_lplay_mid: assert property (p_lplay_mid) else $error("Path not connected.");
    // Top code on the left amplifier path into left playback gives +6dB.
    property p_lplay_low;
        @(posedge clk_i) disable iff (srst_i)
        (lplay_r[3:1] == 3'b111) |=> path_gain_db_o[17:12] == 6'h0c;
    endproperty
    a_lplay_low: assert property (p_lplay_low) else $error("Gain +6dB wrong.");
    // Code 010 on the right amplifier path into right playback gives -9dB.
    property p_rplay_mid;
        @(posedge clk_i) disable iff (srst_i)
        (rplay_r[7:5] == 3'b010) |=> path_gain_db_o[29:24] == 6'h2e;
    endproperty
    a_rplay_mid: assert property (p_rplay_mid) else $error("Gain -9dB wrong.");
    // Code 000 on the left amplifier path into right playback disconnects it.
    property p_rplay_low;
        @(posedge clk_i) disable iff (srst_i)
        (rplay_r[3:1] == 3'b000) |=> !path_connected_o[5] && path_gain_db_o[35:30] == 6'h00;
    endproperty
    a_rplay_low: assert property (p_rplay_low) else $error("Path not off.");
    // A non-zero code connects the third left path into the record mixer.
    property p_lrec_hi;
        @(posedge clk_i) disable iff (srst_i)
        (lrec_r[11:9] != 3'b000) |=> path_connected_o[6];
    endproperty
    a_lrec_hi: assert property (p_lrec_hi) else $error("Record path not on.");
    // Code 001 on the second left path into the record mixer gives -12dB.
    property p_lrec_low;
        @(posedge clk_i) disable iff (srst_i)
        (lrec_r[3:1] == 3'b001) |=> path_gain_db_o[47:42] == 6'h28;
    endproperty
    a_lrec_low: assert property (p_lrec_low) else $error("Record gain wrong.");
    // Spare slots never report a connected path or a gain.
    property p_spare;
        @(posedge clk_i) disable iff (srst_i)
        path_connected_o[11:8] == 4'h0 && path_gain_db_o[71:48] == 24'h00_0000;
    endproperty
    a_spare: assert property (p_spare) else $error("Spare slot active.");
    // An error answer always comes with ready.
    property p_err;
        @(posedge clk_i) disable iff (srst_i)
        pslverr_o |-> pready_o;
    endproperty
    a_err: assert property (p_err) else $error("Error without ready.");
    // Read data is zero outside the answer cycle.
    property p_rdata_idle;
        @(posedge clk_i) disable iff (srst_i)
        !pready_o |-> prdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Stray read data.");
    // Reserved bits of the control and left playback registers never hold a one.
    property p_reserved;
        @(posedge clk_i) disable iff (srst_i)
        (auxb_r & ~`AMRG_M_AUXB) == 16'h0000 && (lplay_r & ~`AMRG_M_LPLAY) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bit set.");
    // Reads and record boost are the remaining main scenarios.
    c_rd: cover property (@(posedge clk_i) pready_o && !pwrite_i && prdata_o != 32'h0000_0000);
    c_boost: cover property (@(posedge clk_i) left_pga_rec_boost_o);
endmodule : amrg_regs

//--- common/amrg_map.svh
`ifndef AMRG_MAP_SVH
`define AMRG_MAP_SVH
// Register indices; byte address is four times the index.
`define AMRG_IDX_AUXB_CTRL 8'h5d
`define AMRG_IDX_LPLAY_GAIN 8'h60
`define AMRG_IDX_RPLAY_GAIN 8'h61
`define AMRG_IDX_LREC_GAIN 8'h62
// Field positions.
`define AMRG_B_AUXB_ENA 15
`define AMRG_B_RDAC 12
`define AMRG_B_LDAC 11
`define AMRG_B_ATTN 10
`define AMRG_B_RREC 9
`define AMRG_B_AUXA 2
`define AMRG_B_RPLAY 1
`define AMRG_B_LPLAY 0
`define AMRG_F_HI3 15
`define AMRG_F_MID3 11
`define AMRG_F_PGA_R 7
`define AMRG_F_PGA_L 3
`define AMRG_B_BOOST 0
// Writable masks and reset value.
`define AMRG_M_AUXB 16'h9e03
`define AMRG_M_LPLAY 16'h0eee
`define AMRG_M_RPLAY 16'he0ee
`define AMRG_M_LREC 16'h0e0f
`define AMRG_RST 16'h0000
`endif

//--- common/amrg_pkg.sv
package amrg_pkg;
    // Mixer path gain in half-dB units; disconnected reported separately.
    typedef logic [2:0] amrg_gain_code_t;
    typedef logic signed [5:0] amrg_gain_db_t;
endpackage : amrg_pkg

//--- tb/testbench.sv
`timescale 1ns/10ps
`include "amrg_map.svh"
module testbench;
    logic clk_i = 1'b0; // Bench clock, 4 ns period.
    logic srst_i = 1'b1; // Reset, held for three cycles.
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0; // Idle bus.
    logic [11:0] paddr_i = 12'h000; // Byte address.
    logic [31:0] pwdata_i = 32'h0000_0000; // Write data.
    logic [3:0] pstrb_i = 4'hf; // Full strobes keep both data bytes live.
    logic [31:0] prdata_o; // Read data.
    logic pready_o, pslverr_o; // Answer.
    logic [6:0] ctrl; // Mixer control outputs gathered.
    logic [11:0] conn; // Path connected flags.
    logic [71:0] gain; // Path gains.
    logic boost; // Record boost.
    logic [15:0] mirror [4]; // Expected register contents.
    logic [11:0] addr_tab [4]; // Register byte addresses.
    logic [15:0] mask_tab [4]; // Writable bits per register.
    int errors = 0; // Mismatches.
    int cmp_count = 0; // Comparisons.
    int k; // Kind of random step.
    int r; // Register picked at random.
    logic [15:0] d; // Data picked at random.

    always #2 clk_i = ~clk_i;

    amrg_regs #(.ADDR_W(12)) amrg_regs_inst (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .aux_out_b_mixer_enable_o(ctrl[6]), .right_dac_to_aux_b_o(ctrl[5]),
        .left_dac_to_aux_b_o(ctrl[4]), .aux_b_minus_6db_o(ctrl[3]),
        .right_rec_mix_to_aux_b_o(ctrl[2]), .right_play_mix_to_aux_b_o(ctrl[1]),
        .left_play_mix_to_aux_b_o(ctrl[0]), .path_connected_o(conn),
        .path_gain_db_o(gain), .left_pga_rec_boost_o(boost));

    //////////////////////////////////////////////////////////////////////////////
    // The gain code of one mixer path slot, taken from the mirror.
    function automatic logic [2:0] code_of(input int s);
        logic [2:0] c;
        case (s)
            0: c = mirror[1][11:9];
            1: c = mirror[1][7:5];
            2: c = mirror[1][3:1];
            3: c = mirror[2][15:13];
            4: c = mirror[2][7:5];
            5: c = mirror[2][3:1];
            6: c = mirror[3][11:9];
            7: c = mirror[3][3:1];
            default: c = 3'h0; // Unused slots stay disconnected.
        endcase
        return c;
    endfunction : code_of

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] wd,
                          input logic [15:0] exp_rd, input logic exp_err);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {16'h0000, wd};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        // The wait ends once pready is high; if it never rises, the watchdog ends it.
        while (pready_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        if (!wr) chk("read data", {56'h0, exp_rd}, {40'h0, prdata_o});
        chk("slave error", {71'h0, exp_err}, {71'h0, pslverr_o});
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // One idle cycle keeps each strobe to a single change per time step.
        @(posedge clk_i);
    endtask : access

    // Writes a register, then checks every output and the read-back value.
    task automatic wr_chk(input int i, input logic [15:0] v);
        logic [71:0] g;
        logic [11:0] cn;
        logic [6:0] ec;
        g = '0;
        cn = '0;
        access(1'b1, addr_tab[i], v, 16'h0000, 1'b0);
        mirror[i] = v & mask_tab[i];
        ec = {mirror[0][15], mirror[0][12:9], mirror[0][1:0]};
        for (int s = 0; s < 8; s++)
        begin
            cn[s] = (code_of(s) != 3'h0);
            g[6*s +: 6] = cn[s] ? 6'(6 * code_of(s) - 30) : 6'h00;
        end
        // Sample mid-cycle, where the registered outputs have settled.
        @(negedge clk_i);
        chk("ctrl", ec, ctrl);
        chk("conn play", cn[5:0], conn[5:0]);
        chk("conn rec", cn[11:6], conn[11:6]);
        chk("gain play", g[35:0], gain[35:0]);
        chk("gain rec", g[71:36], gain[71:36]);
        chk("boost", mirror[3][0], boost);
        @(posedge clk_i);
        access(1'b0, addr_tab[i], 16'h0000, mirror[i], 1'b0);
    endtask : wr_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    //////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs under a thousand cycles.
    initial
    begin
        #80000;
        errors++;
        finish_test();
    end

    // Main sequence: reset values, all-ones, code sweep, then random traffic.
    initial
    begin
        addr_tab = '{12'({`AMRG_IDX_AUXB_CTRL, 2'b00}), 12'({`AMRG_IDX_LPLAY_GAIN, 2'b00}),
                     12'({`AMRG_IDX_RPLAY_GAIN, 2'b00}), 12'({`AMRG_IDX_LREC_GAIN, 2'b00})};
        mask_tab = '{`AMRG_M_AUXB, `AMRG_M_LPLAY, `AMRG_M_RPLAY, `AMRG_M_LREC};
        mirror = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        void'($urandom(40981));
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 4; i++)
            access(1'b0, addr_tab[i], 16'h0000, 16'h0000, 1'b0);
        // All ones shows which bits are writable; bit 2 of the control must stay clear.
        for (int i = 0; i < 4; i++)
            wr_chk(i, 16'hffff);
        // Every gain code lands in all three left playback fields at once.
        for (int c = 0; c < 8; c++)
            wr_chk(1, 16'((c << 9) | (c << 5) | (c << 1)));
        for (int n = 0; n < 60; n++)
        begin
            k = $urandom % 4;
            r = $urandom % 4;
            d = 16'($urandom);
            if (k == 0)
            begin
                // Misaligned or unmapped places refuse and change nothing.
                access(1'b1, addr_tab[r] + 12'(1 + r % 3), d, 16'h0000, 1'b1);
                access(1'b0, 12'h190, d, 16'h0000, 1'b1);
                // A write with no strobes is accepted but changes nothing.
                pstrb_i <= 4'h0;
                access(1'b1, addr_tab[r], d, 16'h0000, 1'b0);
                pstrb_i <= 4'hf;
                access(1'b0, addr_tab[r], 16'h0000, mirror[r], 1'b0);
            end
            else
                wr_chk(r, d);
        end
        finish_test();
    end
endmodule : testbench
